// *** iwg_regs.svh ***
// register map, field positions, reset values and timing figures of the write guard
// assumes inclusion by bare name from the package and the design modules
`ifndef IWG_REGS_SVH
`define IWG_REGS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define IWG_REG_ST_OV1 8'h00
`define IWG_REG_ST_OV2 8'h01
`define IWG_REG_ST_UV1 8'h02
`define IWG_REG_ST_UV2 8'h03
`define IWG_REG_ST_RUN 8'h04
`define IWG_REG_SAFE 8'h05
`define IWG_REG_CTRL1 8'h06
`define IWG_REG_VMON1 8'h07
`define IWG_REG_VMON2 8'h08
`define IWG_REG_IRQ_FLAG 8'h09
`define IWG_REG_IRQ_MASK 8'h0A
`define IWG_REG_CHALLENGE 8'h0B
`define IWG_REG_ECHO 8'h0C
`define IWG_REG_LAST_GUARDED 8'h08

// ************************************************************
// field layout of the sticky flag vector
// ************************************************************
`define IWG_FLAGS 27
`define IWG_F_OV_SW 0
`define IWG_F_OV_LDO 7
`define IWG_F_UV_SW 11
`define IWG_F_UV_LDO 18
`define IWG_F_CAUSE 22
`define IWG_N_SW 7
`define IWG_N_LDO 4
`define IWG_N_CAUSE 5
`define IWG_CTRL1_SECURE 6

// ************************************************************
// reset values and crc figures
// ************************************************************
`define IWG_RST_CTRL1 7'h7F
`define IWG_RST_VMON1 7'h7F
`define IWG_RST_VMON2 4'hF
`define IWG_RST_MASK 1'h0
`define IWG_RST_LFSR 8'h01
`define IWG_CRC_POLY 8'h1D
`define IWG_CRC_INIT 8'hFF

// ************************************************************
// framing and timing
// ************************************************************
`define IWG_BYTE_LAST_BIT 3'h7
`define IWG_IDX_DATA 3'h2
`define IWG_IDX_CRC 3'h3
`define IWG_IDX_MAX 3'h4
`define IWG_TIMEOUT_MS 10
`define IWG_CLK_KHZ 100000

`endif

// *** iwg_pkg.sv ***
// types shared by the write guard modules
// assumes iwg_regs.svh on the include path
`include "iwg_regs.svh"

package iwg_pkg;

	// ************************************************************
	// guard sequencer states
	// ************************************************************
	typedef enum logic [0:0] {
		IWG_IDLE = 1'b0,
		IWG_PENDING = 1'b1
	} iwg_state_e;

	// ************************************************************
	// one register write
	// ************************************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} iwg_write_s;

	// ************************************************************
	// guarded control bits
	// ************************************************************
	typedef struct packed {
		logic secure_en;
		logic kick_input_standby_watch;
		logic watchdog_standby_enable;
		logic watchdog_counter_enable;
		logic input_overvolt_shutdown_enable;
		logic input_overvolt_lockout_enable;
		logic thermal_watch_enable;
	} iwg_ctrl1_s;

endpackage

// *** iwg_crc8.sv ***
// byte-wise crc-8 accumulator, polynomial and preset from iwg_regs.svh
// assumes bytes arrive one per valid cycle, clear ahead of each transaction
`timescale 1ns/1ps
`include "iwg_regs.svh"

module iwg_crc8 (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// byte stream
	input wire logic clear_i,
	input wire logic valid_i,
	input wire logic [7:0] data_i,
	// running value
	output logic [7:0] crc_o
);

	logic [7:0] next_crc;

	always_comb begin
		next_crc = crc_o ^ data_i;
		for (int i = 0; i < 8; i++) begin
			if (next_crc[7]) begin
				next_crc = {next_crc[6:0], 1'b0} ^ `IWG_CRC_POLY;
			end else begin
				next_crc = {next_crc[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			crc_o <= `IWG_CRC_INIT;
		end else if (clear_i) begin
			crc_o <= `IWG_CRC_INIT;
		end else if (valid_i) begin
			crc_o <= next_crc;
		end
	end

endmodule

// *** iwg_guard.sv ***
// write-path crc check and challenge-echo guard behind the i2c target framer
// assumes the framer delivers write frames only, bit by bit, msb first, with start and stop strobes
`timescale 1ns/1ps
`include "iwg_regs.svh"

// Behaviour
// - crc check runs only when the crc fuse is set
// - a crc byte is computed over each completed write transaction
// - crc mismatch drops the command, sets fault flag, irq low when unmasked
// - crc-8 with polynomial 0x1D, preset 0xFF; host sends matching byte
// - guarded procedure only with the guard fuse set, else direct writes
// - protected write is held pending and a random challenge is loaded
// - matching echo applies the pending write and clears challenge and echo
// - differing echo drops the pending write and clears both registers
// - any other write abandons the pending one and executes normally; here a guarded-register write instead replaces it and loads a new challenge
// - no echo within 10 ms abandons the pending write, back to idle
// - self-test over and undervoltage flags clear by guarded write of one
// - self-test launch by writing one, guarded
// - five safe-state cause flags clear by guarded write of one
// - thermal watch enable is guarded; zero stops thermal detection
// - input overvoltage lockout and shutdown enables are guarded
// - watchdog counter and standby counter enables are guarded
// - standby kick-input watch enable is guarded
// - runtime guard enable is guarded; zero turns protection off
// - per-regulator monitor enables are guarded
// - trial-config pin high bypasses crc and guard outside power-up
// - only whole bytes are used; partial bytes dropped and not acknowledged
module iwg_guard #(
	parameter int TIMEOUT_CYCLES = `IWG_TIMEOUT_MS * `IWG_CLK_KHZ
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// fuses and mode pins
	input wire logic fuse_crc_en_i,
	input wire logic fuse_guard_en_i,
	input wire logic trial_config_pin_i,
	input wire logic powerup_active_i,
	// framer bit stream
	input wire logic frame_start_i,
	input wire logic frame_stop_i,
	input wire logic rx_bit_valid_i,
	input wire logic rx_bit_i,
	output logic ack_o,
	// register read port
	input wire logic rd_req_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// flag set events from the monitors
	input wire logic [`IWG_FLAGS-1:0] flag_set_i,
	// controlled outputs
	output logic [`IWG_FLAGS-1:0] flags_o,
	output logic selftest_launch_o,
	output iwg_pkg::iwg_ctrl1_s ctrl1_o,
	output logic [6:0] buck_monitor_enable_o,
	output logic [3:0] linear_monitor_enable_o,
	output logic irq_out_n_o,
	output logic guard_pending_o
);

	// ************************************************************
	// declarations
	// ************************************************************
	localparam logic [19:0] TIMEOUT_LOAD = 20'(TIMEOUT_CYCLES - 1);

	logic [7:0] shift;
	logic [2:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic in_frame;
	logic [7:0] rx_addr;
	logic [7:0] rx_data;
	logic [7:0] rx_crc;
	logic [7:0] crc_calc;
	logic [7:0] rx_byte;
	logic byte_done;
	iwg_pkg::iwg_state_e state;
	iwg_pkg::iwg_write_s pend;
	iwg_pkg::iwg_write_s apply;
	logic [7:0] challenge_code;
	logic [7:0] challenge_echo;
	logic [7:0] lfsr;
	logic [19:0] timer;
	logic crc_fault;
	logic crc_mask;
	logic bypass;
	logic crc_on;
	logic guard_on;
	logic has_cmd;
	logic crc_match;
	logic commit_ok;
	logic crc_bad;
	logic take_echo;
	logic take_guard;
	logic take_plain;
	logic apply_v;
	logic timeout;
	logic [`IWG_FLAGS-1:0] clr_flags;
	logic [`IWG_FLAGS-1:0] wr_map;

	// ************************************************************
	// mode decode
	// ************************************************************
	assign bypass = trial_config_pin_i & ~powerup_active_i;
	assign crc_on = fuse_crc_en_i & ~bypass;
	assign guard_on = fuse_guard_en_i & ctrl1_o.secure_en & ~bypass;

	// ************************************************************
	// byte assembly
	// ************************************************************
	assign rx_byte = {shift[6:0], rx_bit_i};
	assign byte_done = in_frame & rx_bit_valid_i & ~frame_start_i & ~frame_stop_i
		& (bit_cnt == `IWG_BYTE_LAST_BIT);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			shift <= 8'h00;
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			in_frame <= 1'b0;
			ack_o <= 1'b0;
		end else begin
			ack_o <= byte_done;
			if (frame_start_i) begin
				bit_cnt <= 3'h0;
				byte_cnt <= 3'h0;
				in_frame <= 1'b1;
			end else if (frame_stop_i) begin
				in_frame <= 1'b0; // a trailing partial byte dies here
			end else if (in_frame && rx_bit_valid_i) begin
				shift <= rx_byte;
				bit_cnt <= bit_cnt + 3'h1;
				if (byte_done && byte_cnt != `IWG_IDX_MAX) begin
					byte_cnt <= byte_cnt + 3'h1;
				end
			end
		end
	end

	// bytes past the crc byte are ignored
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rx_addr <= 8'h00;
			rx_data <= 8'h00;
			rx_crc <= 8'h00;
		end else if (byte_done) begin
			if (byte_cnt == `IWG_IDX_DATA - 3'h1) begin
				rx_addr <= rx_byte;
			end
			if (byte_cnt == `IWG_IDX_DATA) begin
				rx_data <= rx_byte;
			end
			if (byte_cnt == `IWG_IDX_CRC) begin
				rx_crc <= rx_byte;
			end
		end
	end

	// ************************************************************
	// crc over target address, register address and data
	// ************************************************************
	iwg_crc8 u_crc (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.clear_i(frame_start_i),
		.valid_i(byte_done && byte_cnt < `IWG_IDX_CRC),
		.data_i(rx_byte),
		.crc_o(crc_calc)
	);

	assign has_cmd = frame_stop_i & in_frame & (byte_cnt > `IWG_IDX_DATA);
	assign crc_match = (byte_cnt == `IWG_IDX_MAX) & (rx_crc == crc_calc);
	assign commit_ok = has_cmd & (~crc_on | crc_match);
	assign crc_bad = has_cmd & crc_on & ~crc_match;

	// ************************************************************
	// guard sequencer
	// ************************************************************
	assign take_echo = commit_ok & (state == iwg_pkg::IWG_PENDING) & (rx_addr == `IWG_REG_ECHO);
	assign take_guard = commit_ok & ~take_echo & guard_on & (rx_addr <= `IWG_REG_LAST_GUARDED);
	assign take_plain = commit_ok & ~take_echo & ~take_guard;
	assign apply_v = take_plain | (take_echo & (rx_data == challenge_code));
	assign apply.addr = take_echo ? pend.addr : rx_addr;
	assign apply.data = take_echo ? pend.data : rx_data;
	assign timeout = (state == iwg_pkg::IWG_PENDING) & (timer == 20'h0) & ~commit_ok;

	// free-running generator, never zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr <= `IWG_RST_LFSR;
		end else begin
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= iwg_pkg::IWG_IDLE;
			pend <= '0;
			timer <= 20'h0;
		end else begin
			case (state)
				iwg_pkg::IWG_IDLE: begin
					if (take_guard) begin
						state <= iwg_pkg::IWG_PENDING;
						pend <= '{addr: rx_addr, data: rx_data};
						timer <= TIMEOUT_LOAD;
					end
				end
				iwg_pkg::IWG_PENDING: begin
					if (take_guard) begin
						pend <= '{addr: rx_addr, data: rx_data};
						timer <= TIMEOUT_LOAD;
					end else if (take_echo || take_plain || timeout) begin
						state <= iwg_pkg::IWG_IDLE;
					end else begin
						timer <= timer - 20'h1;
					end
				end
				default: begin
					state <= iwg_pkg::IWG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			challenge_code <= 8'h00;
			challenge_echo <= 8'h00;
		end else if (take_guard) begin
			challenge_code <= lfsr;
			challenge_echo <= 8'h00;
		end else if (take_echo || timeout || (take_plain && state == iwg_pkg::IWG_PENDING)) begin
			challenge_code <= 8'h00;
			challenge_echo <= 8'h00;
		end else if (take_plain && rx_addr == `IWG_REG_ECHO) begin
			challenge_echo <= rx_data;
		end
	end

	// ************************************************************
	// register writes
	// ************************************************************
	always_comb begin
		wr_map = '0;
		case (apply.addr)
			`IWG_REG_ST_OV1: wr_map[`IWG_F_OV_SW +: `IWG_N_SW] = apply.data[6:0];
			`IWG_REG_ST_OV2: wr_map[`IWG_F_OV_LDO +: `IWG_N_LDO] = apply.data[3:0];
			`IWG_REG_ST_UV1: wr_map[`IWG_F_UV_SW +: `IWG_N_SW] = apply.data[6:0];
			`IWG_REG_ST_UV2: wr_map[`IWG_F_UV_LDO +: `IWG_N_LDO] = apply.data[3:0];
			`IWG_REG_SAFE: wr_map[`IWG_F_CAUSE +: `IWG_N_CAUSE] = apply.data[4:0];
			default: wr_map = '0;
		endcase
	end

	generate
		for (genvar k = 0; k < `IWG_FLAGS; k++) begin : g_flag
			assign clr_flags[k] = apply_v & wr_map[k];
			// a set in the clearing cycle wins
			always_ff @(posedge clock_i or posedge rst_i) begin
				if (rst_i) begin
					flags_o[k] <= 1'b0;
				end else if (flag_set_i[k]) begin
					flags_o[k] <= 1'b1;
				end else if (clr_flags[k]) begin
					flags_o[k] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			selftest_launch_o <= 1'b0;
		end else begin
			selftest_launch_o <= apply_v & (apply.addr == `IWG_REG_ST_RUN) & apply.data[0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl1_o <= `IWG_RST_CTRL1;
			buck_monitor_enable_o <= `IWG_RST_VMON1;
			linear_monitor_enable_o <= `IWG_RST_VMON2;
		end else if (apply_v) begin
			if (apply.addr == `IWG_REG_CTRL1) begin
				ctrl1_o <= apply.data[6:0];
			end
			if (apply.addr == `IWG_REG_VMON1) begin
				buck_monitor_enable_o <= apply.data[6:0];
			end
			if (apply.addr == `IWG_REG_VMON2) begin
				linear_monitor_enable_o <= apply.data[3:0];
			end
		end
	end

	// ************************************************************
	// crc fault flag and interrupt pin
	// ************************************************************
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			crc_fault <= 1'b0;
			crc_mask <= `IWG_RST_MASK;
		end else begin
			if (crc_bad) begin
				crc_fault <= 1'b1;
			end else if (apply_v && apply.addr == `IWG_REG_IRQ_FLAG && apply.data[0]) begin
				crc_fault <= 1'b0;
			end
			if (apply_v && apply.addr == `IWG_REG_IRQ_MASK) begin
				crc_mask <= apply.data[0];
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			irq_out_n_o <= 1'b1;
			guard_pending_o <= 1'b0;
		end else begin
			irq_out_n_o <= ~(crc_fault & ~crc_mask);
			guard_pending_o <= (state == iwg_pkg::IWG_PENDING);
		end
	end

	// ************************************************************
	// register reads, no side effects
	// ************************************************************
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= 8'h00;
		end else if (rd_req_i) begin
			case (rd_addr_i)
				`IWG_REG_ST_OV1: rd_data_o <= {1'b0, flags_o[`IWG_F_OV_SW +: `IWG_N_SW]};
				`IWG_REG_ST_OV2: rd_data_o <= {4'h0, flags_o[`IWG_F_OV_LDO +: `IWG_N_LDO]};
				`IWG_REG_ST_UV1: rd_data_o <= {1'b0, flags_o[`IWG_F_UV_SW +: `IWG_N_SW]};
				`IWG_REG_ST_UV2: rd_data_o <= {4'h0, flags_o[`IWG_F_UV_LDO +: `IWG_N_LDO]};
				`IWG_REG_SAFE: rd_data_o <= {3'h0, flags_o[`IWG_F_CAUSE +: `IWG_N_CAUSE]};
				`IWG_REG_CTRL1: rd_data_o <= {1'b0, ctrl1_o};
				`IWG_REG_VMON1: rd_data_o <= {1'b0, buck_monitor_enable_o};
				`IWG_REG_VMON2: rd_data_o <= {4'h0, linear_monitor_enable_o};
				`IWG_REG_IRQ_FLAG: rd_data_o <= {7'h00, crc_fault};
				`IWG_REG_IRQ_MASK: rd_data_o <= {7'h00, crc_mask};
				`IWG_REG_CHALLENGE: rd_data_o <= challenge_code;
				`IWG_REG_ECHO: rd_data_o <= challenge_echo;
				default: rd_data_o <= 8'h00;
			endcase
		end
	end

endmodule

// *** iwg_guard_props.sv ***
// checker for the write guard, sees only the iwg_guard ports
// assumes iwg_regs.svh and iwg_pkg compiled first
`timescale 1ns/1ps
`include "iwg_regs.svh"

module iwg_guard_props #(
	parameter int TIMEOUT_CYCLES = 50
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// fuses and mode pins
	input wire logic fuse_crc_en_i,
	input wire logic fuse_guard_en_i,
	input wire logic trial_config_pin_i,
	input wire logic powerup_active_i,
	// framer bit stream
	input wire logic frame_start_i,
	input wire logic frame_stop_i,
	input wire logic rx_bit_valid_i,
	input wire logic rx_bit_i,
	input wire logic ack_o,
	// register read port
	input wire logic rd_req_i,
	input wire logic [7:0] rd_addr_i,
	input wire logic [7:0] rd_data_o,
	// flags and controlled outputs
	input wire logic [`IWG_FLAGS-1:0] flag_set_i,
	input wire logic [`IWG_FLAGS-1:0] flags_o,
	input wire logic selftest_launch_o,
	input wire iwg_pkg::iwg_ctrl1_s ctrl1_o,
	input wire logic [6:0] buck_monitor_enable_o,
	input wire logic [3:0] linear_monitor_enable_o,
	input wire logic irq_out_n_o,
	input wire logic guard_pending_o
);
	logic in_fr;
	logic ack_due;
	logic [5:0] cnt;
	int pend_cnt;

	default clocking dcb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	// ************************************************************
	// helper logic
	// ************************************************************
	// an ack follows every whole byte; start or stop swallow a bit that meets them
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			in_fr <= 1'b0;
			cnt <= 6'h00;
			ack_due <= 1'b0;
		end else begin
			ack_due <= in_fr && !frame_start_i && !frame_stop_i && rx_bit_valid_i && cnt[2:0] == 3'h7;
			if (frame_start_i) begin
				in_fr <= 1'b1;
				cnt <= 6'h00;
			end else if (frame_stop_i) begin
				in_fr <= 1'b0;
			end else if (in_fr && rx_bit_valid_i) begin
				cnt <= cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pend_cnt <= 0;
		else
			pend_cnt <= (guard_pending_o && !frame_stop_i) ? pend_cnt + 1 : 0;
	end

	// ************************************************************
	// assertions
	// ************************************************************
	ack_timing_a: assert property (ack_o == ack_due) else $error("ack out of step");
	pend_source_a: assert property ($rose(guard_pending_o) |-> ($past(frame_stop_i) || $past(frame_stop_i, 2))
		&& $past(fuse_guard_en_i, 2) && !($past(trial_config_pin_i, 2) && !$past(powerup_active_i, 2)))
		else $error("pending without guarded frame");
	pend_bound_a: assert property (pend_cnt <= TIMEOUT_CYCLES + 3) else $error("pending outlived timeout");
	ctrl_cause_a: assert property (!$stable(ctrl1_o) |-> $past(frame_stop_i) || $past(frame_stop_i, 2))
		else $error("control bits changed outside a frame");
	launch_pulse_a: assert property (selftest_launch_o |-> ($past(frame_stop_i) || $past(frame_stop_i, 2)) ##1 !selftest_launch_o)
		else $error("selftest launch misshaped");
	flag_clear_a: assert property ((($past(flags_o) & ~flags_o) != 0) |-> $past(frame_stop_i) || $past(frame_stop_i, 2))
		else $error("flag cleared outside a frame");
	flag_set_a: assert property ((flag_set_i != 0) |=> (flags_o & $past(flag_set_i)) == $past(flag_set_i))
		else $error("flag set request lost");
	irq_cause_a: assert property ($fell(irq_out_n_o) |-> $past(frame_stop_i, 2) || $past(frame_stop_i, 3))
		else $error("irq fell without a frame");
endmodule

bind iwg_guard iwg_guard_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
	.clock_i, .rst_i, .fuse_crc_en_i, .fuse_guard_en_i, .trial_config_pin_i, .powerup_active_i,
	.frame_start_i, .frame_stop_i, .rx_bit_valid_i, .rx_bit_i, .ack_o, .rd_req_i, .rd_addr_i, .rd_data_o,
	.flag_set_i, .flags_o, .selftest_launch_o, .ctrl1_o, .buck_monitor_enable_o, .linear_monitor_enable_o,
	.irq_out_n_o, .guard_pending_o
);

// *** iwg_host_model.sv ***
// host controller model: sends write frames bit by bit to the framer side
// assumes a free running clock; frames are started only by the send task
`timescale 1ns/1ps

module iwg_host_model #(
	parameter logic [7:0] TARGET_ADDR = 8'h08
) (
	// clock
	input wire logic clock_i,
	// framer side
	output logic frame_start_o,
	output logic frame_stop_o,
	output logic rx_bit_valid_o,
	output logic rx_bit_o
);
	initial begin
		frame_start_o = 1'b0;
		frame_stop_o = 1'b0;
		rx_bit_valid_o = 1'b0;
		rx_bit_o = 1'b0;
	end

	function automatic logic [7:0] crc8(input logic [23:0] m);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 23; i >= 0; i--)
			c = (c[7] ^ m[i]) ? {c[6:0], 1'b0} ^ 8'h1D : {c[6:0], 1'b0};
		return c;
	endfunction

	// bad flips bit 0 of the check byte; nb below 32 cuts the frame short
	task automatic send(input logic [7:0] ra, input logic [7:0] d, input logic bad, input int nb, input int gap);
		logic [31:0] w;
		w = {TARGET_ADDR, ra, d, crc8({TARGET_ADDR, ra, d}) ^ {7'h00, bad}};
		@(posedge clock_i); #1;
		frame_start_o = 1'b1;
		for (int i = 0; i < nb; i++) begin
			repeat (gap) begin
				@(posedge clock_i); #1;
				frame_start_o = 1'b0;
				rx_bit_valid_o = 1'b0;
				rx_bit_o = ~rx_bit_o;
			end
			@(posedge clock_i); #1;
			frame_start_o = 1'b0;
			rx_bit_valid_o = 1'b1;
			rx_bit_o = w[31 - i];
		end
		@(posedge clock_i); #1;
		frame_start_o = 1'b0;
		rx_bit_valid_o = 1'b0;
		frame_stop_o = 1'b1;
		@(posedge clock_i); #1;
		frame_stop_o = 1'b0;
		rx_bit_o = ~rx_bit_o;
		repeat (3) @(posedge clock_i);
		#1;
	endtask
endmodule

// *** iwg_guard_tb.sv ***
// self-checking bench for iwg_guard with the host model on the frame side
// assumes iwg_pkg, checker and host model compiled first
`timescale 1ns/1ps
`include "iwg_regs.svh"

module iwg_guard_tb;
	localparam int TMO = 50;
	logic clock_i, rst_i, fuse_crc_en_i, fuse_guard_en_i, trial_config_pin_i, powerup_active_i;
	logic frame_start_i, frame_stop_i, rx_bit_valid_i, rx_bit_i, ack_o, rd_req_i, selftest_launch_o;
	logic irq_out_n_o, guard_pending_o;
	logic [7:0] rd_addr_i, rd_data_o, v;
	logic [`IWG_FLAGS-1:0] flag_set_i, flags_o, f;
	iwg_pkg::iwg_ctrl1_s ctrl1_o;
	logic [6:0] buck_monitor_enable_o;
	logic [3:0] linear_monitor_enable_o;
	int err_total = 0;
	int comparisons = 0;
	int exp_q[$];
	int e;
	logic rd_seen = 1'b0;
	int launches = 0;

	iwg_guard #(.TIMEOUT_CYCLES(TMO)) dut (.clock_i, .rst_i, .fuse_crc_en_i, .fuse_guard_en_i,
		.trial_config_pin_i, .powerup_active_i, .frame_start_i, .frame_stop_i, .rx_bit_valid_i, .rx_bit_i,
		.ack_o, .rd_req_i, .rd_addr_i, .rd_data_o, .flag_set_i, .flags_o, .selftest_launch_o, .ctrl1_o,
		.buck_monitor_enable_o, .linear_monitor_enable_o, .irq_out_n_o, .guard_pending_o);
	iwg_host_model host (.clock_i, .frame_start_o(frame_start_i), .frame_stop_o(frame_stop_i),
		.rx_bit_valid_o(rx_bit_valid_i), .rx_bit_o(rx_bit_i));

	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// x below zero reads without checking
	task automatic rd(input logic [7:0] a, input int x);
		exp_q.push_back(x);
		@(posedge clock_i); #1;
		rd_req_i = 1'b1;
		rd_addr_i = a;
		@(posedge clock_i); #1;
		rd_req_i = 1'b0;
		v = rd_data_o;
		@(posedge clock_i); #1;
	endtask

	always @(posedge clock_i) begin
		if (rd_seen) begin
			e = exp_q.pop_front();
			if (e >= 0)
				cmp(rd_data_o, e);
		end
		rd_seen <= rd_req_i;
	end

	// the launch pulse stands one cycle, so it is counted at every edge
	always @(posedge clock_i) begin
		if (selftest_launch_o === 1'b1)
			launches++;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.send(a, d, 1'b0, 32, 0);
	endtask

	task automatic gw(input logic [7:0] a, input logic [7:0] d, input logic [7:0] flip);
		wr(a, d);
		cmp(guard_pending_o, 1);
		rd(`IWG_REG_CHALLENGE, -1);
		cmp(v != 8'h00, 1);
		wr(`IWG_REG_ECHO, v ^ flip);
		cmp(guard_pending_o, 0);
		rd(`IWG_REG_CHALLENGE, 0);
		rd(`IWG_REG_ECHO, 0);
	endtask

	initial begin
		repeat (30000) @(posedge clock_i);
		err_total++;
		complete_run();
	end

	initial begin
		rst_i = 1'b1;
		fuse_crc_en_i = 1'b1;
		fuse_guard_en_i = 1'b1;
		trial_config_pin_i = 1'b0;
		powerup_active_i = 1'b0;
		rd_req_i = 1'b0;
		rd_addr_i = 8'h00;
		flag_set_i = '0;
		void'($urandom(32'h0969));
		repeat (5) @(posedge clock_i);
		#1 rst_i = 1'b0;
		rd(`IWG_REG_CTRL1, 'h7F);
		rd(`IWG_REG_VMON1, 'h7F);
		rd(`IWG_REG_VMON2, 'h0F);
		rd(`IWG_REG_IRQ_MASK, 0);
		rd(`IWG_REG_ST_RUN, 0);
		rd(8'h0D, 0);
		cmp(irq_out_n_o, 1);
		cmp(launches, 0);
		$display("test reset done");
		gw(`IWG_REG_CTRL1, 8'h7E, 8'h00);
		cmp(ctrl1_o, 'h7E);
		gw(`IWG_REG_VMON1, 8'($urandom) & 8'h3F, 8'h01 << ($urandom % 8));
		cmp(buck_monitor_enable_o, 'h7F);
		$display("test echo done");
		wr(`IWG_REG_VMON2, 8'h00);
		wr(`IWG_REG_IRQ_MASK, 8'h01);
		cmp(guard_pending_o, 0);
		rd(`IWG_REG_IRQ_MASK, 1);
		cmp(linear_monitor_enable_o, 'hF);
		wr(`IWG_REG_VMON2, 8'h00);
		rd(`IWG_REG_CHALLENGE, -1);
		repeat (TMO + 5) @(posedge clock_i);
		#1;
		cmp(guard_pending_o, 0);
		rd(`IWG_REG_CHALLENGE, 0);
		wr(`IWG_REG_ECHO, v);
		cmp(linear_monitor_enable_o, 'hF);
		$display("test cancel done");
		host.send(`IWG_REG_IRQ_MASK, 8'h00, 1'b1, 32, 0);
		rd(`IWG_REG_IRQ_MASK, 1);
		rd(`IWG_REG_IRQ_FLAG, 1);
		cmp(irq_out_n_o, 1);
		wr(`IWG_REG_IRQ_MASK, 8'h00);
		cmp(irq_out_n_o, 0);
		wr(`IWG_REG_IRQ_FLAG, 8'h01);
		rd(`IWG_REG_IRQ_FLAG, 0);
		cmp(irq_out_n_o, 1);
		host.send(`IWG_REG_IRQ_MASK, 8'h01, 1'b0, 28, 0);
		rd(`IWG_REG_IRQ_FLAG, 1);
		rd(`IWG_REG_IRQ_MASK, 0);
		wr(`IWG_REG_IRQ_FLAG, 8'h01);
		host.send(`IWG_REG_IRQ_MASK, 8'h01, 1'b0, 20, 0);
		rd(`IWG_REG_IRQ_FLAG, 0);
		rd(`IWG_REG_IRQ_MASK, 0);
		fuse_crc_en_i = 1'b0;
		host.send(`IWG_REG_IRQ_MASK, 8'h01, 1'b1, 32, $urandom % 3);
		rd(`IWG_REG_IRQ_MASK, 1);
		rd(`IWG_REG_IRQ_FLAG, 0);
		fuse_crc_en_i = 1'b1;
		wr(`IWG_REG_IRQ_MASK, 8'h00);
		$display("test crc done");
		fuse_guard_en_i = 1'b0;
		wr(`IWG_REG_CTRL1, 8'h7D);
		cmp(ctrl1_o, 'h7D);
		wr(`IWG_REG_ST_RUN, 8'h01);
		cmp(launches, 1);
		fuse_guard_en_i = 1'b1;
		trial_config_pin_i = 1'b1;
		powerup_active_i = 1'b1;
		wr(`IWG_REG_CTRL1, 8'h3F);
		cmp(guard_pending_o, 1);
		wr(`IWG_REG_IRQ_MASK, 8'h00);
		cmp(ctrl1_o, 'h7D);
		powerup_active_i = 1'b0;
		wr(`IWG_REG_CTRL1, 8'h3D);
		cmp(ctrl1_o, 'h3D);
		trial_config_pin_i = 1'b0;
		wr(`IWG_REG_VMON1, 8'h55);
		cmp(buck_monitor_enable_o, 'h55);
		wr(`IWG_REG_CTRL1, 8'h7F);
		cmp(ctrl1_o, 'h7F);
		$display("test bypass done");
		f = `IWG_FLAGS'($urandom);
		flag_set_i = f;
		@(posedge clock_i); #1;
		flag_set_i = '0;
		@(posedge clock_i); #1;
		cmp(flags_o, f);
		gw(`IWG_REG_SAFE, 8'h1F, 8'h00);
		f = f & ~(`IWG_FLAGS'(5'h1F) << `IWG_F_CAUSE);
		cmp(flags_o, f);
		gw(`IWG_REG_ST_OV1, 8'h7F, 8'h00);
		cmp(flags_o, f & ~`IWG_FLAGS'(7'h7F));
		gw(`IWG_REG_ST_RUN, 8'h01, 8'h00);
		cmp(launches, 2);
		$display("test flags done");
		complete_run();
	end
endmodule
